// >>> amp_diag_pkg.sv
// Shared constants and carriers for the amplifier diagnostic control block
package amp_diag_pkg;

  // Timing figures in their own units and derived cycle counts at 100 MHz
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SETTLE_MS       = 500;
  localparam int unsigned EVAL_MIN_MS     = 300;
  localparam int unsigned EVAL_MAX_MS     = 1000;
  localparam int unsigned SIG_GOOD_MS     = 300;
  localparam int unsigned VOFS_PERSIST_MS = 90;
  localparam int unsigned SETTLE_CYC      = SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned EVAL_MIN_CYC    = EVAL_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned EVAL_MAX_CYC    = EVAL_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned SIG_GOOD_CYC    = SIG_GOOD_MS * (CLK_HZ / 1000);
  localparam int unsigned VOFS_CYC        = VOFS_PERSIST_MS * (CLK_HZ / 1000);

  // Field positions of the detector control byte
  localparam int unsigned CTL_OL_START  = 0;
  localparam int unsigned CTL_HPF_EN    = 2;
  localparam int unsigned CTL_IOFS_START = 3;
  // Field positions of the routing, skip config and threshold bytes
  localparam int unsigned ROUTE_VOFS    = 7;
  localparam int unsigned ROUTE_TW_LO   = 4;
  localparam int unsigned SKIP_CFG_LO   = 4;
  localparam logic [1:0]  SKIP_CFG_ON   = 2'h1;
  localparam int unsigned THR_IOFS_LO   = 3;
  localparam int unsigned THR_OL_SEL    = 6;
  // Status bit positions of the offset and load status byte
  localparam int unsigned ST_OL_FOUND   = 0;
  localparam int unsigned ST_OL_VALID   = 1;
  localparam int unsigned ST_OL_DONE    = 2;
  localparam int unsigned ST_VOFS       = 3;
  localparam int unsigned ST_IOFS_FOUND = 5;
  localparam int unsigned ST_IOFS_DONE  = 6;
  localparam int unsigned ST_INOFS      = 7;
  // Status bit positions of the thermal and skip status byte
  localparam int unsigned ST_SKIP       = 0;
  localparam int unsigned ST_TW_LO      = 4;
  // Reset value of every status byte
  localparam logic [7:0]  STATUS_RST    = 8'h00;

  // Device state machine states as seen by this block
  typedef enum logic [2:0] {
    FSM_STANDBY, FSM_DIAG_SUPPLY, FSM_ECO, FSM_MUTE, FSM_PLAY
  } device_state_e;

  // Analog sense conditions, already qualified by the front end
  typedef struct packed {
    logic       sig_above_thr;  // Input above amplitude threshold
    logic       load_open;      // Average impedance above threshold
    logic       iofs_over;      // Current offset above threshold
    logic       iofs_ready;     // Current offset measurement finished
    logic       in_ofs_over;    // Filtered input offset above -18dBFs
    logic       vofs_fault;     // Feedback pin offset fault
    logic       skip_miss;      // Two consecutive commutations missed
    logic [3:0] tw_level;       // Thermal warning levels four..one
    logic       tsd;            // Shutdown temperature exceeded
  } sense_s;

endpackage

// >>> amp_diagnostic_control.sv
// Diagnostic sequencing, filtering and reporting for the amplifier channel
`timescale 1ns/100ps
module amp_diagnostic_control #(
  parameter int unsigned SETTLE_CYC   = amp_diag_pkg::SETTLE_CYC,
  parameter int unsigned EVAL_MIN_CYC = amp_diag_pkg::EVAL_MIN_CYC,
  parameter int unsigned EVAL_MAX_CYC = amp_diag_pkg::EVAL_MAX_CYC,
  parameter int unsigned SIG_GOOD_CYC = amp_diag_pkg::SIG_GOOD_CYC,
  parameter int unsigned VOFS_CYC     = amp_diag_pkg::VOFS_CYC
) (
  input  wire logic                        i_mclk,
  input  wire logic                        i_resetn,
  input  wire logic                        i_ol_start_set,      // Host writes start bit 0
  input  wire logic                        i_iofs_start_set,    // Host writes start bit 3
  input  wire logic                        i_hpf_enable,        // Control bit 2
  input  wire logic                        i_vofs_enable,       // Output offset detector on
  input  wire logic [7:0]                  i_diag_pin_routing_byte,
  input  wire logic [7:0]                  i_skip_detect_config_byte,
  input  wire logic [7:0]                  i_threshold_select_byte,
  input  wire amp_diag_pkg::device_state_e i_device_state,
  input  wire amp_diag_pkg::sense_s        i_sense,             // From analog front end
  output logic [7:0]                       o_detector_control_byte,
  output logic [7:0]                       o_offset_load_status_byte,
  output logic [7:0]                       o_thermal_skip_status_byte,
  output logic                             o_meas_power_on,
  output logic                             o_ol_evaluating,
  output logic                             o_ol_amp_thr_low,    // 40 mFs instead of 67 mFs
  output logic [1:0]                       o_iofs_thr_sel,
  output logic                             o_iofs_measure,
  output logic                             o_hpf_active,
  output logic                             o_power_stage_off,
  output logic                             o_force_supply_diag,
  output logic                             o_diag_open_drain_pin_o,
  output logic                             o_diag_open_drain_pin_oe
);

  // Refuse timing parameters that the counters cannot serve
  if (EVAL_MIN_CYC > EVAL_MAX_CYC || SIG_GOOD_CYC > EVAL_MAX_CYC || VOFS_CYC < 1 ||
      SETTLE_CYC < 1 || EVAL_MIN_CYC < 1) begin : g_bad_timing
    $error("amp_diagnostic_control: inconsistent timing parameters");
  end

  typedef enum logic [1:0] {OL_IDLE, OL_SETTLE, OL_EVAL} ol_state_e;

  ol_state_e   ol_state;
  logic [31:0] ol_cnt;
  logic [31:0] good_cnt;
  logic [31:0] vofs_cnt;
  logic        ol_start;
  logic        iofs_start;
  logic        iofs_running;
  logic        ol_done;
  logic        ol_valid;
  logic        ol_found;
  logic        iofs_done;
  logic        iofs_found;
  logic        vofs_flag;
  logic        in_ofs_flag;
  logic        skip_flag;
  logic [3:0]  tw_flag;
  logic        tsd_latched;

  // Decoded conditions
  wire logic in_play     = (i_device_state == amp_diag_pkg::FSM_PLAY);
  wire logic in_mute     = (i_device_state == amp_diag_pkg::FSM_MUTE);
  wire logic mute_play   = in_play || in_mute;
  wire logic ol_abort    = (ol_state != OL_IDLE) && !in_play;
  wire logic sig_good    = (good_cnt >= SIG_GOOD_CYC);
  wire logic eval_end    = (ol_state == OL_EVAL) && ((ol_cnt >= EVAL_MAX_CYC - 1) ||
                           (sig_good && ol_cnt >= EVAL_MIN_CYC - 1));
  wire logic ol_finish   = eval_end && in_play;
  wire logic iofs_finish = iofs_running && i_sense.iofs_ready && mute_play;
  wire logic vofs_active = i_vofs_enable && mute_play;
  wire logic vofs_fault  = vofs_active && i_sense.vofs_fault;
  wire logic skip_en     = (i_skip_detect_config_byte[amp_diag_pkg::SKIP_CFG_LO +: 2] ==
                            amp_diag_pkg::SKIP_CFG_ON);
  wire logic [2:0] tw_sel = i_diag_pin_routing_byte[amp_diag_pkg::ROUTE_TW_LO +: 3];

  // Open-load test sequence: settle, then evaluate
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ol_state <= OL_IDLE;
      ol_cnt   <= 32'h0;
    end else if (ol_abort || ol_finish) begin
      ol_state <= OL_IDLE;
      ol_cnt   <= 32'h0;
    end else begin
      case (ol_state)
        OL_IDLE: begin
          if (ol_start && in_play) begin
            ol_state <= OL_SETTLE;
          end
        end
        OL_SETTLE: begin
          if (ol_cnt >= SETTLE_CYC - 1) begin
            ol_state <= OL_EVAL;
            ol_cnt   <= 32'h0;
          end else begin
            ol_cnt <= ol_cnt + 32'h1;
          end
        end
        default: begin
          ol_cnt <= ol_cnt + 32'h1;
        end
      endcase
    end
  end

  // Time the input spends above the amplitude threshold during evaluation
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      good_cnt <= 32'h0;
    end else if (ol_state != OL_EVAL) begin
      good_cnt <= 32'h0;
    end else if (i_sense.sig_above_thr && !sig_good) begin
      good_cnt <= good_cnt + 32'h1;
    end
  end

  // Start bits: set by host, cleared by device on completion, the open-load bit also on abort; set wins
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ol_start   <= 1'b0;
      iofs_start <= 1'b0;
    end else begin
      if (i_ol_start_set) begin
        ol_start <= 1'b1;
      end else if (ol_finish || ol_abort) begin
        ol_start <= 1'b0;
      end
      if (i_iofs_start_set) begin
        iofs_start <= 1'b1;
      end else if (iofs_finish) begin
        iofs_start <= 1'b0;
      end
    end
  end

  // Open-load results; a new start clears done until the next completion
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ol_done  <= 1'b0;
      ol_valid <= 1'b0;
      ol_found <= 1'b0;
    end else if (ol_finish) begin
      ol_done  <= 1'b1;
      ol_valid <= sig_good;
      ol_found <= sig_good && i_sense.load_open;
    end else if (i_ol_start_set || ol_abort) begin
      ol_done <= 1'b0;
    end
  end

  // Current offset single shot, held until mute or play
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      iofs_running <= 1'b0;
      iofs_done    <= 1'b0;
      iofs_found   <= 1'b0;
    end else if (iofs_finish) begin
      iofs_running <= 1'b0;
      iofs_done    <= 1'b1;
      iofs_found   <= i_sense.iofs_over;
    end else if (iofs_start && mute_play && !iofs_running) begin
      iofs_running <= 1'b1;
      iofs_done    <= 1'b0;
    end
  end

  // Output voltage offset persistence filter
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      vofs_cnt  <= 32'h0;
      vofs_flag <= 1'b0;
    end else if (!vofs_fault) begin
      vofs_cnt  <= 32'h0;
      vofs_flag <= 1'b0;
    end else if (vofs_cnt >= VOFS_CYC - 1) begin
      vofs_flag <= 1'b1;
    end else begin
      vofs_cnt <= vofs_cnt + 32'h1;
    end
  end

  // Level flags: input offset, skipping, thermal, shutdown
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      in_ofs_flag <= 1'b0;
      skip_flag   <= 1'b0;
      tw_flag     <= 4'h0;
      tsd_latched <= 1'b0;
    end else begin
      in_ofs_flag <= i_sense.in_ofs_over;
      skip_flag   <= skip_en && i_sense.skip_miss;
      tw_flag     <= i_sense.tw_level;
      tsd_latched <= i_sense.tsd;
    end
  end

  // Diagnostic pin pull-down sources
  wire logic [3:0] tw_route;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tw
      assign tw_route[g] = tw_flag[g] && (tw_sel > 3'(g));
    end
  endgenerate
  wire logic pull_vofs = vofs_flag && i_diag_pin_routing_byte[amp_diag_pkg::ROUTE_VOFS];

  // Status and control readback, all from flip-flops except the high-pass bit, taken straight from i_hpf_enable
  always_comb begin
    o_detector_control_byte = amp_diag_pkg::STATUS_RST;
    o_detector_control_byte[amp_diag_pkg::CTL_OL_START]   = ol_start;
    o_detector_control_byte[amp_diag_pkg::CTL_HPF_EN]     = i_hpf_enable;
    o_detector_control_byte[amp_diag_pkg::CTL_IOFS_START] = iofs_start;
    o_offset_load_status_byte = amp_diag_pkg::STATUS_RST;
    o_offset_load_status_byte[amp_diag_pkg::ST_OL_FOUND]   = ol_found;
    o_offset_load_status_byte[amp_diag_pkg::ST_OL_VALID]   = ol_valid;
    o_offset_load_status_byte[amp_diag_pkg::ST_OL_DONE]    = ol_done;
    o_offset_load_status_byte[amp_diag_pkg::ST_VOFS]       = vofs_flag;
    o_offset_load_status_byte[amp_diag_pkg::ST_IOFS_FOUND] = iofs_found;
    o_offset_load_status_byte[amp_diag_pkg::ST_IOFS_DONE]  = iofs_done;
    o_offset_load_status_byte[amp_diag_pkg::ST_INOFS]      = in_ofs_flag;
    o_thermal_skip_status_byte = amp_diag_pkg::STATUS_RST;
    o_thermal_skip_status_byte[amp_diag_pkg::ST_SKIP]        = skip_flag;
    o_thermal_skip_status_byte[amp_diag_pkg::ST_TW_LO +: 4]  = tw_flag;
  end

  // Analog controls and open-drain pin
  assign o_meas_power_on          = (ol_state != OL_IDLE);
  assign o_ol_evaluating          = (ol_state == OL_EVAL);
  assign o_ol_amp_thr_low         = i_threshold_select_byte[amp_diag_pkg::THR_OL_SEL];
  assign o_iofs_thr_sel           = i_threshold_select_byte[amp_diag_pkg::THR_IOFS_LO +: 2];
  assign o_iofs_measure           = iofs_running;
  assign o_hpf_active             = i_hpf_enable;
  assign o_power_stage_off        = tsd_latched;
  assign o_force_supply_diag      = tsd_latched;
  assign o_diag_open_drain_pin_o  = 1'b0;
  assign o_diag_open_drain_pin_oe = pull_vofs || skip_flag || (|tw_route);

  // Checks next to the logic; completion without a competing host write
  sequence s_ol_complete;
    ol_finish && !i_ol_start_set;
  endsequence
  property p_ol_done_clears_start;
    @(posedge i_mclk) disable iff (!i_resetn)
      s_ol_complete |=> ol_done && !ol_start;
  endproperty
  a_ol_done_clears_start: assert property (p_ol_done_clears_start)
    else $error("open-load completion did not set done and clear start");

  property p_ol_abort;
    @(posedge i_mclk) disable iff (!i_resetn)
      ol_abort && !i_ol_start_set |=> !ol_done && !ol_start && ol_state == OL_IDLE;
  endproperty
  a_ol_abort: assert property (p_ol_abort)
    else $error("leaving play did not abort open-load test");

  property p_valid_needs_signal;
    @(posedge i_mclk) disable iff (!i_resetn)
      ol_finish |=> ol_valid == $past(sig_good);
  endproperty
  a_valid_needs_signal: assert property (p_valid_needs_signal)
    else $error("valid flag disagrees with signal quality");

  property p_found_only_valid;
    @(posedge i_mclk) disable iff (!i_resetn) ol_found |-> ol_valid;
  endproperty
  a_found_only_valid: assert property (p_found_only_valid)
    else $error("open load reported without valid result");

  property p_vofs_clears;
    @(posedge i_mclk) disable iff (!i_resetn) !vofs_fault |=> !vofs_flag && vofs_cnt == 0;
  endproperty
  a_vofs_clears: assert property (p_vofs_clears)
    else $error("output offset flag not cleared with fault");

  property p_vofs_persist;
    @(posedge i_mclk) disable iff (!i_resetn) $rose(vofs_flag) |-> vofs_cnt == VOFS_CYC - 1;
  endproperty
  a_vofs_persist: assert property (p_vofs_persist)
    else $error("output offset flag set before persistence time");

  property p_vofs_pin;
    @(posedge i_mclk) disable iff (!i_resetn)
      vofs_flag && i_diag_pin_routing_byte[amp_diag_pkg::ROUTE_VOFS] |-> o_diag_open_drain_pin_oe;
  endproperty
  a_vofs_pin: assert property (p_vofs_pin)
    else $error("diagnostic pin not pulled for output offset");

  property p_iofs_held;
    @(posedge i_mclk) disable iff (!i_resetn) !mute_play |=> !$rose(iofs_running);
  endproperty
  a_iofs_held: assert property (p_iofs_held)
    else $error("current offset test started outside mute or play");

  property p_iofs_done;
    @(posedge i_mclk) disable iff (!i_resetn)
      iofs_finish && !i_iofs_start_set |=> iofs_done && !iofs_start;
  endproperty
  a_iofs_done: assert property (p_iofs_done)
    else $error("current offset completion mishandled");

  property p_skip_pin;
    @(posedge i_mclk) disable iff (!i_resetn) skip_flag |-> o_diag_open_drain_pin_oe;
  endproperty
  a_skip_pin: assert property (p_skip_pin)
    else $error("skip flag without pin pull-down");

endmodule

// >>> amp_host_model.sv
// Host-side model that issues diagnostic start requests to the block
`timescale 1ns/100ps
module amp_host_model (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_ol_req,
  input  wire logic       i_iofs_req,
  input  wire logic       i_retry_en,
  input  wire logic [7:0] i_status,
  output logic            o_ol_start_set,
  output logic            o_iofs_start_set
);
  logic done_seen;
  logic retry;
  // Relaunch once when a finished open-load test reports an unusable signal
  always_ff @(negedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_seen <= 1'b0;
      retry     <= 1'b0;
    end else begin
      done_seen <= i_status[amp_diag_pkg::ST_OL_DONE];
      retry     <= i_retry_en & i_status[amp_diag_pkg::ST_OL_DONE]
                   & ~i_status[amp_diag_pkg::ST_OL_VALID] & ~done_seen;
    end
  end
  // Start writes are one-cycle pulses
  assign o_ol_start_set   = i_ol_req | retry;
  assign o_iofs_start_set = i_iofs_req;
endmodule

// >>> testbench.sv
// Self-checking bench for the amplifier diagnostic control block
`timescale 1ns/100ps
module testbench;
  localparam int S    = 20;
  localparam int EMIN = 10;
  localparam int EMAX = 40;
  localparam int V    = 8;
  logic                        mclk, resetn, ol_req, iofs_req, retry_en, hpf, vofs_en;
  logic                        ol_set, iofs_set, meas, evl, thr_low, iofs_meas, hpf_act;
  logic                        pso, fsd, pin_o, pin_oe;
  logic [7:0]                  route, skip_cfg, thr, ctl, st0, st1;
  logic [1:0]                  iofs_sel;
  amp_diag_pkg::device_state_e state;
  amp_diag_pkg::sense_s        sense;
  int                          n_fail, tests_run, n;

  // Free-running 100 MHz clock
  always #5 mclk = ~mclk;

  amp_host_model HOST (.i_mclk(mclk), .i_resetn(resetn), .i_ol_req(ol_req),
    .i_iofs_req(iofs_req), .i_retry_en(retry_en), .i_status(st0),
    .o_ol_start_set(ol_set), .o_iofs_start_set(iofs_set));

  amp_diagnostic_control #(.SETTLE_CYC(S), .EVAL_MIN_CYC(EMIN), .EVAL_MAX_CYC(EMAX),
    .SIG_GOOD_CYC(10), .VOFS_CYC(V)) DUT (
    .i_mclk(mclk), .i_resetn(resetn), .i_ol_start_set(ol_set),
    .i_iofs_start_set(iofs_set), .i_hpf_enable(hpf), .i_vofs_enable(vofs_en),
    .i_diag_pin_routing_byte(route), .i_skip_detect_config_byte(skip_cfg),
    .i_threshold_select_byte(thr), .i_device_state(state), .i_sense(sense),
    .o_detector_control_byte(ctl), .o_offset_load_status_byte(st0),
    .o_thermal_skip_status_byte(st1), .o_meas_power_on(meas), .o_ol_evaluating(evl),
    .o_ol_amp_thr_low(thr_low), .o_iofs_thr_sel(iofs_sel), .o_iofs_measure(iofs_meas),
    .o_hpf_active(hpf_act), .o_power_stage_off(pso), .o_force_supply_diag(fsd),
    .o_diag_open_drain_pin_o(pin_o), .o_diag_open_drain_pin_oe(pin_oe));

  task automatic summarize;
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask

  // One open-load test in play with the given signal quality and load state
  task automatic ol_test(input logic sig, input logic open);
    int lim;
    lim = sig ? S + EMIN : S + EMAX;
    sense.sig_above_thr = sig;
    sense.load_open = open;
    ol_req = 1'b1;
    tick(1);
    ol_req = 1'b0;
    chk(8'(ctl[0]), 8'h01, "open-load start readback");
    tick(1);
    chk(8'(meas), 8'h01, "measurement power on");
    n = 2;
    while (st0[2] !== 1'b1 && n < 200) begin
      if (n == S + 1 || n == S + 2) begin
        chk(8'(evl), 8'(n == S + 2), "evaluation after settling");
      end
      tick(1);
      n++;
    end
    if (n >= 200) begin
      $display("CHECK FAILED at %0t: open-load test never finished", $time);
      n_fail++;
      summarize();
    end
    chk(8'(n >= lim && n <= lim + 4), 8'h01, "open-load duration");
    chk({5'h00, st0[2:0]}, {5'h00, 1'b1, sig, sig & open}, "open-load result");
    chk(8'(ctl[0]), 8'h00, "open-load start cleared");
    chk({6'h00, meas, evl}, 8'h00, "measurement off after test");
  endtask

  // Main sequence of scenarios
  initial begin
    {mclk, resetn, ol_req, iofs_req, retry_en, hpf, vofs_en} = 7'h00;
    {route, skip_cfg, thr} = 24'h000000;
    state = amp_diag_pkg::FSM_STANDBY;
    sense = '0;
    n_fail = 0;
    tests_run = 0;
    tick(4);
    resetn = 1'b1;
    tick(1);
    chk(st0, 8'h00, "status byte 0 reset");
    chk(st1, 8'h00, "status byte 1 reset");
    chk({ctl[7:3], ctl[1:0], pin_oe}, 8'h00, "control and pin reset");
    hpf = 1'b1;
    tick(1);
    chk({6'h00, hpf_act, ctl[2]}, 8'h03, "high-pass enable");
    for (int i = 0; i < 4; i++) begin
      thr = {1'b0, 1'(i), 1'b0, 2'(i), 3'h0};
      tick(1);
      chk({5'h00, thr_low, iofs_sel}, {5'h00, 1'(i), 2'(i)}, "threshold selects");
    end
    thr = 8'h00;
    state = amp_diag_pkg::FSM_PLAY;
    ol_test(1'b1, 1'b1);
    ol_test(1'b1, 1'b0);
    retry_en = 1'b1;
    ol_test(1'b0, 1'b1);
    tick(3);
    chk(8'(ctl[0]), 8'h01, "relaunch after invalid result");
    retry_en = 1'b0;
    state = amp_diag_pkg::FSM_MUTE;
    tick(2);
    chk({5'h00, meas, ctl[0], st0[2]}, 8'h00, "abort on leaving play");
    for (int r = 0; r < 2; r++) begin
      state = amp_diag_pkg::FSM_STANDBY;
      iofs_req = 1'b1;
      tick(1);
      iofs_req = 1'b0;
      tick(3);
      chk({6'h00, ctl[3], iofs_meas}, 8'h02, "current test held");
      state = r ? amp_diag_pkg::FSM_PLAY : amp_diag_pkg::FSM_MUTE;
      tick(2);
      chk(8'(iofs_meas), 8'h01, "current test running");
      sense.iofs_over = 1'(r);
      sense.iofs_ready = 1'b1;
      tick(1);
      sense.iofs_ready = 1'b0;
      tick(1);
      chk({5'h00, st0[6:5], ctl[3]}, {5'h00, 1'b1, 1'(r), 1'b0}, "current result");
    end
    for (int v = 1; v >= 0; v--) begin
      sense.in_ofs_over = 1'(v);
      tick(2);
      chk(8'(st0[7]), 8'(v), "input offset flag");
    end
    vofs_en = 1'b1; // Feedback taken after the filter
    route = 8'h80;
    for (int r = 0; r < 2; r++) begin
      state = r ? amp_diag_pkg::FSM_PLAY : amp_diag_pkg::FSM_MUTE;
      sense.vofs_fault = 1'b1;
      tick(V - 2);
      chk({6'h00, st0[3], pin_oe}, 8'h00, "output offset early");
      n = 0;
      while (st0[3] !== 1'b1 && n < 4) begin
        tick(1);
        n++;
      end
      if (st0[3] !== 1'b1) begin
        $display("CHECK FAILED at %0t: output offset flag never set", $time);
        n_fail++;
        summarize();
      end
      chk(8'(n), 8'h02, "output offset persistence");
      chk({6'h00, st0[3], pin_oe}, 8'h03, "output offset flag and pin");
      route = 8'h00;
      tick(2);
      chk({6'h00, pin_o, pin_oe}, 8'h00, "pin released unrouted");
      route = 8'h80;
      sense.vofs_fault = 1'b0;
      tick(1);
      chk(8'(st0[3]), 8'h00, "output offset clear");
    end
    {vofs_en, route} = 9'h000;
    for (int c = 0; c < 4; c++) begin
      skip_cfg = 8'(c << 4);
      sense.skip_miss = 1'b1;
      tick(2);
      chk({6'h00, st1[0], pin_oe}, {6'h00, 2'(c == 1 ? 3 : 0)}, "skip flag");
      sense.skip_miss = 1'b0;
      tick(2);
      chk({6'h00, st1[0], pin_oe}, 8'h00, "skip released");
    end
    skip_cfg = 8'h00;
    for (int g = 0; g < 4; g++) begin
      for (int s = 0; s < 8; s++) begin
        route = 8'(s << 4);
        sense.tw_level = 4'(1 << g);
        tick(2);
        chk({st1[7:4], 3'h0, pin_oe}, {4'(1 << g), 3'h0, 1'(s > g)}, "thermal");
      end
    end
    sense.tw_level = 4'h0;
    sense.tsd = 1'b1;
    tick(2);
    chk({6'h00, pso, fsd}, 8'h03, "thermal shutdown");
    summarize();
  end

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge mclk);
    $display("CHECK FAILED at %0t: run timed out", $time);
    n_fail++;
    summarize();
  end
endmodule
